// ===== lens_gpio_pkg.sv
package lens_gpio_pkg;
    localparam int NPADS_DEF  = 12;
    localparam int NSTEPS_DEF = 4;
    localparam int ADC_W      = 10;
    localparam int ADC_CH     = 3;

    // Timing
    localparam int CLK_HZ         = 100_000_000;
    localparam int TOGGLE_DIV     = 2;
    localparam int SAMPLE_MAX_SPS = 36000;
    localparam int SAMPLE_GAP_CYC = (CLK_HZ + SAMPLE_MAX_SPS - 1) / SAMPLE_MAX_SPS;

    // Register offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_OUT      = 8'h04;
    localparam logic [7:0] OFS_DIR      = 8'h08;
    localparam logic [7:0] OFS_PIN      = 8'h0c;
    localparam logic [7:0] OFS_STAT     = 8'h10;
    localparam logic [7:0] OFS_MASK     = 8'h14;
    localparam logic [7:0] OFS_LOOPS    = 8'h18;
    localparam logic [7:0] OFS_ADC      = 8'h1c;
    localparam logic [7:0] OFS_STEP_VAL = 8'h40;
    localparam logic [7:0] OFS_STEP_LEN = 8'h60;

    // Field positions
    localparam int CTRL_CLK_ON = 0;
    localparam int CTRL_WAVE   = 1;
    localparam int CTRL_LAST   = 4;
    localparam int LEN_NOTIFY  = 16;
    localparam int ST_STEP     = 0;
    localparam int ST_DONE     = 1;
    localparam int ST_ADC      = 2;

    // Reset values
    localparam logic [2:0]  LAST_RST = 3'h0;
    localparam logic [15:0] LOOP_RST = 16'h0000;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic             valid;
        logic [ADC_W-1:0] data;
    } adc_res_s;
endpackage : lens_gpio_pkg

// ===== lens_actuator_waveform_gpio.sv
// Contract
// - Twelve pads, each driven high or low on its own.
// - Waveform timebase, step sequencer and ADC requests run only while the clock gate is on.
// - Waveform steps change pads at most once every two clock periods.
// - Host and microcontroller both control pads, directly or by waveform.
// - Direct output register writes reach the output-enabled pads right after the write, while waveform mode is off.
// - Once started, programmed waveforms run with no further input.
// - Selected waveform points raise a wakeup and a pollable status bit.
// - Wakeup is sent only while the microcontroller sleeps.
// - Each pad can be a high-impedance input.
// - Every pad level is mirrored in a readable register bit.
// - Shared 10-bit ADC samples three feedback inputs only during blanking.
// - Feedback results sit in registers, at most about 36000 samples/s.
// - Step commands over the register port become pad waveforms.
module lens_actuator_waveform_gpio
    import lens_gpio_pkg::*;
#(
    parameter int NPADS  = NPADS_DEF,
    parameter int NSTEPS = NSTEPS_DEF
) (
    // Clock and reset
    input  wire logic             I_SYS_CLK,
    input  wire logic             I_SYS_RST,
    // Register port, shared by host and microcontroller
    input  wire reg_req_s         I_REG,
    output logic [31:0]           O_RDATA,
    // Pads
    input  wire logic [NPADS-1:0] I_PAD_IN,
    output logic [NPADS-1:0]      O_PAD_OUT,
    output logic [NPADS-1:0]      O_PAD_OE,
    // Microcontroller and interrupt
    input  wire logic             I_MCU_SLEEP,
    output logic                  O_MCU_WAKE,
    output logic                  O_IRQ,
    // Sensor ADC sharing
    input  wire logic             I_HBLANK,
    input  wire adc_res_s         I_ADC,
    output logic                  O_ADC_REQ,
    output logic [1:0]            O_ADC_SEL
);
    localparam int IW    = (NSTEPS > 1) ? $clog2(NSTEPS) : 1;
    localparam int GAP_W = $clog2(SAMPLE_GAP_CYC + 1);

    if (NPADS < 1 || NPADS > 16 || NSTEPS < 2 || NSTEPS > 8) begin : g_chk
        $error("lens gpio: NPADS must be 1..16 and NSTEPS 2..8");
    end

    typedef enum {G_IDLE, G_RUN} gen_state_e;

    function automatic logic [15:0] len_of(input logic [16:0] v);
        return (v[15:0] == 16'h0000) ? 16'h0001 : v[15:0];
    endfunction : len_of

    function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
        return a[7:5] == base[7:5];
    endfunction : in_bank

    gen_state_e         gst_r;
    logic               clk_on_r;
    logic               wave_r;
    logic [2:0]         last_r;
    logic [NPADS-1:0]   out_r;
    logic [NPADS-1:0]   dir_r;
    logic [NPADS-1:0]   s1_r;
    logic [NPADS-1:0]   s2_r;
    logic [NPADS-1:0]   s3_r;
    logic [NPADS-1:0]   pin_r;
    logic [NPADS-1:0]   gen_r;
    logic [NPADS-1:0]   sval_r [NSTEPS];
    logic [16:0]        slen_r [NSTEPS];
    logic [IW-1:0]      idx_r;
    logic [15:0]        dur_r;
    logic [15:0]        loops_r;
    logic               half_r;
    logic [2:0]         stat_r;
    logic [2:0]         mask_r;
    logic [ADC_W-1:0]   adc_r [ADC_CH];
    logic [GAP_W-1:0]   gap_r;
    logic [1:0]         sel_r;

    // Decode
    logic             wr_ctrl;
    logic             wr_out;
    logic             wr_dir;
    logic             wr_stat;
    logic             wr_mask;
    logic             wr_loops;
    logic             any_ctl;
    logic [2:0]       rd_idx;
    logic             rd_step_ok;
    logic [31:0]      rd_mux;
    assign wr_ctrl    = I_REG.wr && I_REG.addr == OFS_CTRL;
    assign wr_out     = I_REG.wr && I_REG.addr == OFS_OUT;
    assign wr_dir     = I_REG.wr && I_REG.addr == OFS_DIR;
    assign wr_stat    = I_REG.wr && I_REG.addr == OFS_STAT;
    assign wr_mask    = I_REG.wr && I_REG.addr == OFS_MASK;
    assign wr_loops   = I_REG.wr && I_REG.addr == OFS_LOOPS;
    assign any_ctl    = wr_ctrl || wr_out || wr_dir;
    assign rd_idx     = I_REG.addr[4:2];
    assign rd_step_ok = 32'(rd_idx) < NSTEPS && I_REG.addr[1:0] == 2'b00;

    // Generator decode
    logic             tick;
    logic             step_last;
    logic             step_end;
    logic             run_done;
    logic             step_note;
    logic [IW-1:0]    nxt_idx;
    assign tick      = clk_on_r && half_r;
    assign step_last = 3'(idx_r) >= last_r || idx_r == IW'(NSTEPS - 1);
    assign step_end  = gst_r == G_RUN && tick && dur_r <= 16'h0001;
    assign run_done  = step_end && step_last && loops_r == 16'h0001;
    assign step_note = step_end && slen_r[idx_r][LEN_NOTIFY];
    assign nxt_idx   = step_last ? '0 : idx_r + 1'b1;

    // Status decode; a set in the clearing cycle survives
    logic             sample_ok;
    logic [2:0]       stat_set;
    logic [2:0]       stat_clr;
    logic [2:0]       stat_nxt;
    logic [NPADS-1:0] pad_nxt;
    logic [NPADS-1:0] pin_nxt;
    assign sample_ok = O_ADC_REQ && I_ADC.valid;
    assign stat_set  = {sample_ok, run_done, step_note};
    assign stat_clr  = wr_stat ? I_REG.wdata[2:0] : 3'h0;
    assign stat_nxt  = (stat_r & ~stat_clr) | stat_set;
    assign pad_nxt   = (wave_r ? gen_r : out_r) & dir_r;
    assign pin_nxt   = (s3_r & ~(s2_r ^ s3_r)) | (pin_r & (s2_r ^ s3_r));

    assign rd_mux =
        (I_REG.addr == OFS_CTRL)  ? 32'({last_r, 2'b00, wave_r, clk_on_r}) :
        (I_REG.addr == OFS_OUT)   ? 32'(out_r) :
        (I_REG.addr == OFS_DIR)   ? 32'(dir_r) :
        (I_REG.addr == OFS_PIN)   ? 32'(pin_r) :
        (I_REG.addr == OFS_STAT)  ? 32'(stat_r) :
        (I_REG.addr == OFS_MASK)  ? 32'(mask_r) :
        (I_REG.addr == OFS_LOOPS) ? 32'(loops_r) :
        (I_REG.addr == OFS_ADC)   ? 32'(adc_r[0]) :
        (I_REG.addr == OFS_ADC + 8'h04) ? 32'(adc_r[1]) :
        (I_REG.addr == OFS_ADC + 8'h08) ? 32'(adc_r[2]) :
        (in_bank(I_REG.addr, OFS_STEP_VAL) && rd_step_ok) ? 32'(sval_r[rd_idx[IW-1:0]]) :
        (in_bank(I_REG.addr, OFS_STEP_LEN) && rd_step_ok) ? 32'(slen_r[rd_idx[IW-1:0]]) :
        32'h0000_0000;

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            clk_on_r <= 1'b0;
            wave_r   <= 1'b0;
            last_r   <= LAST_RST;
            out_r    <= '0;
            dir_r    <= '0;
            mask_r   <= 3'h0;
        end else begin
            if (wr_ctrl) begin
                clk_on_r <= I_REG.wdata[CTRL_CLK_ON];
                wave_r   <= I_REG.wdata[CTRL_WAVE];
                last_r   <= I_REG.wdata[CTRL_LAST+:3];
            end
            if (wr_out) out_r <= I_REG.wdata[NPADS-1:0];
            if (wr_dir) dir_r <= I_REG.wdata[NPADS-1:0];
            if (wr_mask) mask_r <= I_REG.wdata[2:0];
        end
    end

    for (genvar i = 0; i < NSTEPS; i++) begin : g_step
        always_ff @(posedge I_SYS_CLK) begin
            if (I_SYS_RST) begin
                sval_r[i] <= '0;
                slen_r[i] <= 17'h0_0000;
            end else if (I_REG.wr && I_REG.addr == OFS_STEP_VAL + 8'(4 * i)) begin
                sval_r[i] <= I_REG.wdata[NPADS-1:0];
            end else if (I_REG.wr && I_REG.addr == OFS_STEP_LEN + 8'(4 * i)) begin
                slen_r[i] <= I_REG.wdata[16:0];
            end
        end
    end

    // half-rate step timebase; held low while gated
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) half_r <= 1'b0;
        else           half_r <= clk_on_r && !half_r;
    end

    // autonomous step sequencer; loop count write starts it while the clock gate is on
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            gst_r   <= G_IDLE;
            idx_r   <= '0;
            dur_r   <= 16'h0000;
            loops_r <= LOOP_RST;
        end else if (wr_loops && clk_on_r) begin
            gst_r   <= G_RUN;
            idx_r   <= '0;
            dur_r   <= len_of(slen_r[0]);
            loops_r <= I_REG.wdata[15:0];
        end else if (step_end) begin
            if (run_done) begin
                gst_r <= G_IDLE;
            end else begin
                idx_r <= nxt_idx;
                dur_r <= len_of(slen_r[nxt_idx]);
                if (step_last && loops_r != 16'h0000) loops_r <= loops_r - 16'h0001;
            end
        end else if (gst_r == G_RUN && tick) begin
            dur_r <= dur_r - 16'h0001;
        end
    end

    // Step value follows the index one cycle later; idle holds the last level
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST)           gen_r <= '0;
        else if (gst_r == G_RUN) gen_r <= sval_r[idx_r];
    end

    // per-pad drive; direct value reaches the pad next edge
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            O_PAD_OUT <= '0;
            O_PAD_OE  <= '0;
        end else begin
            O_PAD_OUT <= pad_nxt;
            O_PAD_OE  <= dir_r;
        end
    end

    // Pad mirror: three flops, a change counts once the last two agree
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            s1_r  <= '0;
            s2_r  <= '0;
            s3_r  <= '0;
            pin_r <= '0;
        end else begin
            s1_r  <= I_PAD_IN;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            pin_r <= pin_nxt;
        end
    end

    // notification status; wakeup only into sleep
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            stat_r     <= 3'h0;
            O_MCU_WAKE <= 1'b0;
            O_IRQ      <= 1'b0;
        end else begin
            stat_r     <= stat_nxt;
            O_MCU_WAKE <= |stat_set[ST_DONE:ST_STEP] && I_MCU_SLEEP;
            O_IRQ      <= |(stat_nxt & mask_r);
        end
    end

    // request the ADC only in blanking; spacing caps the rate
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            gap_r     <= '0;
            sel_r     <= 2'h0;
            O_ADC_REQ <= 1'b0;
            O_ADC_SEL <= 2'h0;
        end else begin
            if (sample_ok)               gap_r <= GAP_W'(SAMPLE_GAP_CYC - 1);
            else if (gap_r != '0)        gap_r <= gap_r - 1'b1;
            if (sample_ok)               sel_r <= (sel_r == 2'h2) ? 2'h0 : sel_r + 2'h1;
            O_ADC_REQ <= clk_on_r && I_HBLANK && gap_r == '0 && !sample_ok;
            O_ADC_SEL <= sel_r;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            for (int k = 0; k < ADC_CH; k++) adc_r[k] <= '0;
        end else if (sample_ok && sel_r != 2'h3) begin
            adc_r[sel_r] <= I_ADC.data;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST)     O_RDATA <= 32'h0000_0000;
        else if (I_REG.rd) O_RDATA <= rd_mux;
        else               O_RDATA <= 32'h0000_0000;
    end

    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_SYS_RST);

    sequence direct_wr_s;
        wr_out && !wave_r ##1 !any_ctl;
    endsequence
    sequence sample_s;
        O_ADC_REQ && I_ADC.valid;
    endsequence

    input_undriven_a: assert property ((O_PAD_OUT & ~O_PAD_OE) == '0)
        else $error("input pad driven");
    direct_write_a: assert property (direct_wr_s |=> O_PAD_OUT == ($past(I_REG.wdata[NPADS-1:0], 2) & dir_r))
        else $error("direct write not on pads");
    tick_rate_a: assert property (tick |=> !tick)
        else $error("timebase faster than half rate");
    gate_freeze_a: assert property (!clk_on_r && !$past(clk_on_r) |-> !tick && $stable(dur_r))
        else $error("gated port still advancing");
    wake_sleep_a: assert property (O_MCU_WAKE |-> $past(I_MCU_SLEEP))
        else $error("wakeup while running");
    // wakeup pairs with a status bit
    notify_status_a: assert property (O_MCU_WAKE |-> stat_r[ST_STEP] || stat_r[ST_DONE])
        else $error("wakeup without status");
    adc_blank_a: assert property (O_ADC_REQ |-> $past(I_HBLANK))
        else $error("adc request outside blanking");
    adc_spacing_a: assert property (sample_s |=> !O_ADC_REQ [*8])
        else $error("adc sampled too soon");
    run_holds_a: assert property (gst_r == G_RUN && !wr_loops && !step_end |=> gst_r == G_RUN)
        else $error("waveform stopped on its own");
endmodule : lens_actuator_waveform_gpio

// ===== pad_actuator_model.sv
module pad_actuator_model
    import lens_gpio_pkg::*;
#(
    parameter int NPADS = NPADS_DEF
) (
    // Clock
    input  wire logic             i_clk,
    // Pads
    input  wire logic [NPADS-1:0] i_pad_out,
    input  wire logic [NPADS-1:0] i_pad_oe,
    input  wire logic [NPADS-1:0] i_ext,
    output logic [NPADS-1:0]      o_pad_level,
    // Feedback converter
    input  wire logic             i_adc_req,
    input  wire logic [1:0]       i_adc_sel,
    output adc_res_s              o_adc
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic take = i_adc_req && !o_adc.valid;
    assign o_pad_level = (i_pad_oe & i_pad_out) | (~i_pad_oe & i_ext);
    always @(posedge i_clk) begin
        o_adc.valid <= take;
        // Idle data toggles so a stale sample never looks valid
        o_adc.data  <= take ? 10'h100 + 10'(i_adc_sel) : ~o_adc.data;
    end
endmodule : pad_actuator_model

// ===== lens_actuator_waveform_gpio_test.sv
module lens_actuator_waveform_gpio_test
    import lens_gpio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic [11:0] exp_out;
        logic [11:0] exp_oe;
    } row_s;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    reg_req_s    reg_req = '0;
    logic [31:0] rdata;
    logic [11:0] pad_in, pad_out, pad_oe;
    logic [11:0] ext = 12'h000;
    logic        mcu_sleep = 1'b0, mcu_wake, irq, hblank = 1'b0, adc_req;
    logic [1:0]  adc_sel;
    adc_res_s    adc;
    int          n_fail = 0, total_checks = 0, cycles = 0, n_wake = 0, wake0 = 0, cnt;
    logic [31:0] d;
    row_s        rows [6] = '{'{OFS_DIR, 32'hfff, 12'h000, 12'hfff}, '{OFS_OUT, 32'ha5a, 12'ha5a, 12'hfff},
                              '{OFS_OUT, 32'h5a5, 12'h5a5, 12'hfff}, '{OFS_DIR, 32'h0f0, 12'h0a0, 12'h0f0},
                              '{8'h30, 32'hfff, 12'h0a0, 12'h0f0}, '{OFS_DIR, 32'hfff, 12'h5a5, 12'hfff}};

    lens_actuator_waveform_gpio u_dut (.I_SYS_CLK(sys_clk), .I_SYS_RST(sys_rst), .I_REG(reg_req),
        .O_RDATA(rdata), .I_PAD_IN(pad_in), .O_PAD_OUT(pad_out), .O_PAD_OE(pad_oe),
        .I_MCU_SLEEP(mcu_sleep), .O_MCU_WAKE(mcu_wake), .O_IRQ(irq), .I_HBLANK(hblank),
        .I_ADC(adc), .O_ADC_REQ(adc_req), .O_ADC_SEL(adc_sel));
    pad_actuator_model u_model (.i_clk(sys_clk), .i_pad_out(pad_out), .i_pad_oe(pad_oe), .i_ext(ext),
        .o_pad_level(pad_in), .i_adc_req(adc_req), .i_adc_sel(adc_sel), .o_adc(adc));

    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (mcu_wake === 1'b1) n_wake <= n_wake + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict
    task automatic chk32(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk32
    task automatic chk1(input string name, input logic exp, input logic got);
        chk32(name, {31'h0, exp}, {31'h0, got});
    endtask : chk1
    task automatic reg_wr(input logic [7:0] addr, input logic [31:0] data);
        @(posedge sys_clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge sys_clk);
        reg_req <= '0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] addr, output logic [31:0] data);
        @(posedge sys_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 32'h0};
        @(posedge sys_clk);
        reg_req <= '0;
        #1 data = rdata;
    endtask : reg_rd
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : wait_cyc
    // Counts cycles the pads hold a value, after waiting for it to appear
    task automatic hold_len(input logic [11:0] v, output int n);
        n = 0;
        for (int i = 0; i < 40 && pad_out !== v; i++) @(posedge sys_clk);
        while (pad_out === v && n < 40) begin
            @(posedge sys_clk);
            n = n + 1;
        end
    endtask : hold_len

    initial begin
        wait_cyc(5);
        sys_rst <= 1'b0;
        reg_rd(OFS_CTRL, d);
        chk32("ctrl reset", 32'h0, d);
        reg_rd(OFS_DIR, d);
        chk32("dir reset", 32'h0, d);
        chk32("oe reset", 32'h0, {20'h0, pad_oe});
        $display("test reset done");
        foreach (rows[i]) begin
            reg_wr(rows[i].addr, rows[i].wdata);
            wait_cyc(2);
            chk32("pad out", {20'h0, rows[i].exp_out}, {20'h0, pad_out});
            chk32("pad oe", {20'h0, rows[i].exp_oe}, {20'h0, pad_oe});
        end
        $display("test direct rows done");
        ext <= 12'h3c3;
        reg_wr(OFS_DIR, 32'h0f0);
        wait_cyc(6);
        reg_rd(OFS_PIN, d);
        chk32("pin mirror", 32'h3a3, d);
        reg_rd(8'h34, d);
        chk32("unmapped", 32'h0, d);
        reg_wr(OFS_LOOPS, 32'h1);
        reg_rd(OFS_LOOPS, d);
        chk32("gated loops", 32'h0, d);
        $display("test mirror and gate done");
        reg_wr(OFS_STEP_VAL, 32'h111);
        reg_wr(OFS_STEP_VAL + 8'h04, 32'h222);
        reg_wr(OFS_STEP_LEN, 32'h1_0002);
        reg_wr(OFS_STEP_LEN + 8'h04, 32'h3);
        reg_wr(OFS_MASK, 32'h2);
        reg_wr(OFS_DIR, 32'hfff);
        reg_wr(OFS_CTRL, 32'h13);
        mcu_sleep <= 1'b1;
        wake0 = n_wake;
        // Two loops, so step 1 is followed by step 0 again and its length shows
        reg_wr(OFS_LOOPS, 32'h2);
        hold_len(12'h111, cnt);
        chk1("step0 length", 1'b1, cnt >= 3 && cnt <= 5);
        hold_len(12'h222, cnt);
        chk1("step1 length", 1'b1, cnt >= 5 && cnt <= 7);
        wait_cyc(10);
        chk32("wake count", 32'd3, n_wake - wake0);
        reg_rd(OFS_STAT, d);
        chk32("status run", 32'h3, d);
        chk1("irq set", 1'b1, irq);
        reg_wr(OFS_STAT, 32'h3);
        wait_cyc(2);
        chk1("irq cleared", 1'b0, irq);
        mcu_sleep <= 1'b0;
        wake0 = n_wake;
        reg_wr(OFS_LOOPS, 32'h1);
        wait_cyc(40);
        chk32("awake wake", 32'd0, n_wake - wake0);
        reg_rd(OFS_STAT, d);
        chk32("status awake", 32'h3, d);
        reg_wr(OFS_STAT, 32'h7);
        $display("test waveform done");
        hblank <= 1'b1;
        for (int i = 0; i < 3000 && adc_req !== 1'b1; i++) @(posedge sys_clk);
        wait_cyc(5);
        reg_rd(OFS_ADC, d);
        chk32("adc in1", 32'h100, d);
        reg_rd(OFS_STAT, d);
        chk32("status adc", 32'h4, d);
        cnt = 8;
        while (adc_req !== 1'b1 && cnt < 4000) begin
            @(posedge sys_clk);
            cnt = cnt + 1;
        end
        chk1("sample gap", 1'b1, cnt >= SAMPLE_GAP_CYC - 8 && cnt <= SAMPLE_GAP_CYC + 8);
        wait_cyc(5);
        reg_rd(OFS_ADC + 8'h04, d);
        chk32("adc in2", 32'h101, d);
        hblank <= 1'b0;
        cnt = 0;
        repeat (3200) begin
            @(posedge sys_clk);
            if (adc_req === 1'b1) cnt = cnt + 1;
        end
        chk32("no blank req", 32'd0, cnt);
        $display("test feedback done");
        sys_rst <= 1'b1;
        wait_cyc(2);
        sys_rst <= 1'b0;
        chk32("oe mid reset", 32'h0, {20'h0, pad_oe});
        chk32("out mid reset", 32'h0, {20'h0, pad_out});
        reg_rd(OFS_DIR, d);
        chk32("dir mid reset", 32'h0, d);
        $display("test mid reset done");
        print_verdict();
    end
endmodule : lens_actuator_waveform_gpio_test
